// ===== logic/fdxc_pkg.sv
//Contract
// - Expand pulses precede strobes, keep width, recovery
// - Combined width/depth expansion behaves like either alone
// - Writer watches full flag, reader watches empty
// - Paired two-way FIFOs may use any expansion
// - Only first slice strap low; chain out to in
// - Composite flags formed alike from all slices
// - No retransmit pulse while in depth mode
package fdxc_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int SYNC_LAT      = 3;
    // slowest-grade-safe figures for the fastest grade; raise for slower parts
    localparam int T_STROBE_NS   = 65;
    localparam int T_STR_REC_NS  = 15;
    localparam int T_FLAG_NS     = 60;
    localparam int T_XI_W_NS     = 60;
    localparam int T_XI_REC_NS   = 15;
    localparam int T_XI_SET_NS   = 25;
    localparam int T_RS_NS       = 65;
    localparam int T_RSS_NS      = 45;
    localparam int T_RT_NS       = 65;
    localparam int T_RTR_NS      = 15;

    localparam int C_WR     = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_RD     = C_WR + SYNC_LAT;
    localparam int C_REC    = ((T_FLAG_NS > T_STR_REC_NS ? T_FLAG_NS : T_STR_REC_NS)
                              + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT;
    localparam int C_XI_W   = (T_XI_W_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_XI_REC = ((T_XI_SET_NS > T_XI_REC_NS ? T_XI_SET_NS : T_XI_REC_NS)
                              + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_RS     = ((T_RS_NS > T_RSS_NS ? T_RS_NS : T_RSS_NS)
                              + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_RT     = (T_RT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_RTR    = (T_RTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [7:0] A_CTRL     = 8'h00;
    localparam logic [7:0] A_CMD      = 8'h04;
    localparam logic [7:0] A_STATUS   = 8'h08;
    localparam logic [7:0] A_RDATA    = 8'h0c;
    localparam logic [7:0] A_IRQ_STAT = 8'h10;
    localparam logic [7:0] A_IRQ_EN   = 8'h14;
    localparam logic [7:0] A_IRQ_CLR  = 8'h18;

    localparam int CTRL_DEPTH_BIT = 0;
    localparam int CMD_OP_LSB     = 9;
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_EMPTY_BIT   = 1;
    localparam int ST_FULL_BIT    = 2;
    localparam int IRQ_DONE_BIT   = 0;
    localparam int IRQ_REFUSE_BIT = 1;
    localparam int IRQ_AVAIL_BIT  = 2;

    localparam logic [2:0] OP_WRITE  = 3'h1;
    localparam logic [2:0] OP_READ   = 3'h2;
    localparam logic [2:0] OP_XI     = 3'h3;
    localparam logic [2:0] OP_REREAD = 3'h4;
    localparam logic [2:0] OP_RESET  = 3'h5;

    localparam logic       RST_DEPTH  = 1'b0;
    localparam logic [2:0] RST_IRQ_EN = 3'h0;

    typedef enum logic [1:0] {ST_IDLE, ST_RST, ST_PULSE, ST_REC} fdxc_st_t;
endpackage

// ===== logic/fdxc_sync.sv
module fdxc_sync
    import fdxc_pkg::*;
#(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input  wire logic         clock,  // system clock
    input  wire logic         rst_n,  // async reset, active low
    input  wire logic [W-1:0] d,      // asynchronous pin level
    output logic      [W-1:0] q       // filtered level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } fdxc_sync_t;

    fdxc_sync_t s_reg;
    fdxc_sync_t s_next;

    always_comb begin
        s_next    = s_reg;
        s_next.s1 = d;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
        // a bit moves only once two settled stages agree
        for (int i = 0; i < W; i++) begin
            if (s_reg.s2[i] == s_reg.s3[i]) begin
                s_next.q[i] = s_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.q;
endmodule

// ===== logic/fdxc_top.sv
// Implementation choices: the register offsets and register access over APB.
module fdxc_top
    import fdxc_pkg::*;
#(
    parameter int NSLICE = 3
) (
    input  wire logic              clock,              // 200 MHz system clock
    input  wire logic              rst_n,              // async reset, active low
    input  wire logic              psel,               // apb select
    input  wire logic              penable,            // apb access phase
    input  wire logic              pwrite,             // apb direction
    input  wire logic [7:0]        paddr,              // apb byte address
    input  wire logic [31:0]       pwdata,             // apb write data
    output logic      [31:0]       prdata,             // apb read data
    output logic                   pready,             // apb ready
    output logic                   pslverr,            // apb error on unmapped
    output logic                   irq,                // level interrupt
    output logic                   fifo_reset_n,       // chain reset pin
    output logic                   fifo_write_n,       // shared write strobe
    output logic                   fifo_read_n,        // shared read strobe
    output logic      [8:0]        fifo_data_out,      // word to the chain
    input  wire logic [8:0]        fifo_data_in,       // word from the chain
    output logic      [NSLICE-1:0] first_load_strap_n, // per-slice strap / retransmit pin
    output logic                   reread_pulse_n,     // retransmit strobe, single mode
    output logic                   expand_in_n,        // injected pulse into first slice
    input  wire logic [NSLICE-1:0] empty_flag_n,       // per-slice empty flags
    input  wire logic [NSLICE-1:0] full_flag_n         // per-slice full flags
);
    // refused at elaboration: the strap vector and the 8-bit step counter set these limits
    if (NSLICE < 1 || NSLICE > 32) begin
        $error("NSLICE out of range");
    end
    if (C_RD > 255 || C_REC > 255) begin
        $error("cycle counts exceed counter");
    end
    typedef struct packed {
        fdxc_st_t    st;
        logic [7:0]  cnt;
        logic [2:0]  op;
        logic        depth;
        logic [8:0]  dout;
        logic [8:0]  rdata;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_en;
        logic        wr_n;
        logic        rd_n;
        logic        xi_n;
        logic        rt_n;
        logic        rs_n;
        logic        prev_empty;
        logic [31:0] prdata;
    } fdxc_top_t;
    fdxc_top_t s_reg;
    fdxc_top_t s_next;
    logic [NSLICE-1:0] ef_q;
    logic [NSLICE-1:0] ff_q;
    logic [8:0]        din_q;
    logic              comp_empty;
    logic              comp_full;
    logic              apb_wr;
    logic              mapped;
    logic [2:0]        cmd_op;
    logic              refuse;
    logic              busy;
    fdxc_sync #(.W(NSLICE), .RST_VAL('1)) u_ef_sync (
        .clock (clock),
        .rst_n (rst_n),
        .d     (empty_flag_n),
        .q     (ef_q)
    );
    fdxc_sync #(.W(NSLICE), .RST_VAL('1)) u_ff_sync (
        .clock (clock),
        .rst_n (rst_n),
        .d     (full_flag_n),
        .q     (ff_q)
    );
    fdxc_sync #(.W(9), .RST_VAL('0)) u_din_sync (
        .clock (clock),
        .rst_n (rst_n),
        .d     (fifo_data_in),
        .q     (din_q)
    );
    // every slice must agree before the chain counts as empty or full
    assign comp_empty = &(~ef_q);
    assign comp_full  = &(~ff_q);
    assign busy       = (s_reg.st != ST_IDLE);
    assign apb_wr     = psel && penable && pwrite;
    assign cmd_op     = pwdata[CMD_OP_LSB +: 3];
    assign mapped     = (paddr == A_CTRL) || (paddr == A_CMD) || (paddr == A_STATUS) ||
                        (paddr == A_RDATA) || (paddr == A_IRQ_STAT) ||
                        (paddr == A_IRQ_EN) || (paddr == A_IRQ_CLR);
    always_comb begin
        refuse = busy;
        case (cmd_op)
            OP_WRITE:  refuse = busy || comp_full;
            OP_READ:   refuse = busy || comp_empty;
            OP_XI:     refuse = busy || !s_reg.depth;
            OP_REREAD: refuse = busy || s_reg.depth;
            OP_RESET:  refuse = busy;
            default:   refuse = 1'b1;
        endcase
    end
    always_comb begin
        s_next            = s_reg;
        s_next.prev_empty = comp_empty;
        if (apb_wr && paddr == A_IRQ_CLR) begin
            s_next.irq_stat = s_reg.irq_stat & ~pwdata[2:0];
        end
        if (apb_wr && paddr == A_IRQ_EN) begin
            s_next.irq_en = pwdata[2:0];
        end
        // mode switches only between operations so a strobe never straddles it
        if (apb_wr && paddr == A_CTRL && !busy) begin
            s_next.depth = pwdata[CTRL_DEPTH_BIT];
        end
        // a set lands after the clear so a same-cycle event survives
        if (s_reg.prev_empty && !comp_empty) begin
            s_next.irq_stat[IRQ_AVAIL_BIT] = 1'b1;
        end
        case (s_reg.st)
            ST_IDLE: begin
                if (apb_wr && paddr == A_CMD) begin
                    if (refuse) begin
                        s_next.irq_stat[IRQ_REFUSE_BIT] = 1'b1;
                    end else begin
                        s_next.op = cmd_op;
                        s_next.st = ST_PULSE;
                        case (cmd_op)
                            OP_WRITE: begin
                                s_next.dout = pwdata[8:0];
                                s_next.wr_n = 1'b0;
                                s_next.cnt  = 8'(C_WR);
                            end
                            OP_READ: begin
                                s_next.rd_n = 1'b0;
                                s_next.cnt  = 8'(C_RD);
                            end
                            OP_XI: begin
                                // lets the strap-low first slice take over the chain
                                s_next.xi_n = 1'b0;
                                s_next.cnt  = 8'(C_XI_W);
                            end
                            OP_REREAD: begin
                                s_next.rt_n = 1'b0;
                                s_next.cnt  = 8'(C_RT);
                            end
                            default: begin
                                s_next.st   = ST_RST;
                                s_next.rs_n = 1'b0;
                                s_next.cnt  = 8'(C_RS);
                            end
                        endcase
                    end
                end
            end
            ST_RST: begin
                s_next.cnt = s_reg.cnt - 8'h01;
                if (s_reg.cnt == 8'h01) begin
                    s_next.rs_n = 1'b1;
                    s_next.st   = ST_REC;
                    s_next.cnt  = 8'(C_REC);
                end
            end
            ST_PULSE: begin
                s_next.cnt = s_reg.cnt - 8'h01;
                if (s_reg.cnt == 8'h01) begin
                    if (!s_reg.rd_n) begin
                        s_next.rdata = din_q;
                    end
                    s_next.wr_n = 1'b1;
                    s_next.rd_n = 1'b1;
                    s_next.xi_n = 1'b1;
                    s_next.rt_n = 1'b1;
                    s_next.st   = ST_REC;
                    case (s_reg.op)
                        OP_XI:     s_next.cnt = 8'(C_XI_REC);
                        OP_REREAD: s_next.cnt = 8'(C_RTR);
                        default:   s_next.cnt = 8'(C_REC);
                    endcase
                end
            end
            ST_REC: begin
                s_next.cnt = s_reg.cnt - 8'h01;
                if (s_reg.cnt == 8'h01) begin
                    s_next.st                     = ST_IDLE;
                    s_next.irq_stat[IRQ_DONE_BIT] = 1'b1;
                end
            end
            default: begin
                s_next.st = ST_IDLE;
            end
        endcase
        if (psel && !penable) begin
            case (paddr)
                A_CTRL:     s_next.prdata = {31'h0, s_reg.depth};
                A_STATUS:   s_next.prdata = {29'h0, comp_full, comp_empty, busy};
                A_RDATA:    s_next.prdata = {23'h0, s_reg.rdata};
                A_IRQ_STAT: s_next.prdata = {29'h0, s_reg.irq_stat};
                A_IRQ_EN:   s_next.prdata = {29'h0, s_reg.irq_en};
                default:    s_next.prdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_reg            <= '0;
            s_reg.st         <= ST_IDLE;
            s_reg.depth      <= RST_DEPTH;
            s_reg.irq_en     <= RST_IRQ_EN;
            s_reg.wr_n       <= 1'b1;
            s_reg.rd_n       <= 1'b1;
            s_reg.xi_n       <= 1'b1;
            s_reg.rt_n       <= 1'b1;
            s_reg.rs_n       <= 1'b1;
            s_reg.prev_empty <= 1'b0;  // filtered flags reset to not-empty: no false edge
        end else begin
            s_reg <= s_next;
        end
    end
    assign prdata        = s_reg.prdata;
    assign pready        = 1'b1;
    assign pslverr       = psel && penable && !mapped;
    assign irq           = |(s_reg.irq_stat & s_reg.irq_en);
    assign fifo_reset_n  = s_reg.rs_n;
    assign fifo_write_n  = s_reg.wr_n;
    assign fifo_read_n   = s_reg.rd_n;
    assign fifo_data_out = s_reg.dout;
    // shared strap/retransmit pin: strap pattern in depth mode, retransmit otherwise
    assign first_load_strap_n = s_reg.depth ? {{(NSLICE-1){1'b1}}, 1'b0}
                                            : {NSLICE{s_reg.rt_n}};
    assign reread_pulse_n     = s_reg.depth ? 1'b1 : s_reg.rt_n;
    // single mode wants the expand input grounded through reset
    assign expand_in_n        = s_reg.depth ? s_reg.xi_n : 1'b0;
    // helper counters that only the checks read
    logic [7:0] xi_low_cnt;
    logic [7:0] since_xi;
    logic [7:0] wr_low_cnt;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            xi_low_cnt <= 8'h00;
            since_xi   <= 8'hff;
            wr_low_cnt <= 8'h00;
        end else begin
            xi_low_cnt <= s_reg.xi_n ? 8'h00 : xi_low_cnt + 8'h01;
            since_xi   <= !s_reg.xi_n ? 8'h00 : (since_xi == 8'hff ? since_xi : since_xi + 8'h01);
            wr_low_cnt <= s_reg.wr_n ? 8'h00 : wr_low_cnt + 8'h01;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_rst_low;
        $fell(fifo_reset_n) ##1 (!fifo_reset_n && fifo_write_n && fifo_read_n)[*8];
    endsequence
    sequence s_rst_release;
        ##[1:20] $rose(fifo_reset_n);
    endsequence
    property p_xi_width;
        $rose(s_reg.xi_n) |-> xi_low_cnt >= 8'(C_XI_W);
    endproperty
    a_xi_width: assert property (p_xi_width) else $error("expand pulse too short");
    property p_xi_setup;
        ($fell(fifo_write_n) || $fell(fifo_read_n)) |-> since_xi >= 8'(C_XI_REC);
    endproperty
    a_xi_setup: assert property (p_xi_setup) else $error("strobe too close to pulse");
    property p_no_write_full;
        $fell(fifo_write_n) |-> !$past(comp_full);
    endproperty
    a_no_write_full: assert property (p_no_write_full) else $error("write while full");
    property p_no_read_empty;
        $fell(fifo_read_n) |-> !$past(comp_empty);
    endproperty
    a_no_read_empty: assert property (p_no_read_empty) else $error("read while empty");
    property p_no_reread_depth;
        s_reg.depth |-> (s_reg.rt_n && reread_pulse_n && !first_load_strap_n[0]);
    endproperty
    a_no_reread_depth: assert property (p_no_reread_depth) else $error("retransmit in depth");
    property p_strap;
        !fifo_reset_n |-> (s_reg.depth
                           ? (first_load_strap_n == {{(NSLICE-1){1'b1}}, 1'b0} && expand_in_n)
                           : (&first_load_strap_n && !expand_in_n));
    endproperty
    a_strap: assert property (p_strap) else $error("bad strap pattern");
    property p_avail_irq;
        ($past(comp_empty) && !comp_empty) |=> s_reg.irq_stat[IRQ_AVAIL_BIT];
    endproperty
    a_avail_irq: assert property (p_avail_irq) else $error("data-available missed");
    property p_rst_seq;
        s_rst_low |-> s_rst_release;
    endproperty
    a_rst_seq: assert property (p_rst_seq) else $error("reset pulse malformed");
    property p_wr_width;
        $rose(fifo_write_n) |-> wr_low_cnt == 8'(C_WR);
    endproperty
    a_wr_width: assert property (p_wr_width) else $error("write strobe width wrong");
endmodule

// ===== sim/fdxc_chain_model.sv
module fdxc_chain_model
    import fdxc_pkg::*;
#(
    parameter int NSLICE = 3,
    parameter int DEPTH  = 2
) (
    input  wire logic              clock,              // sampling clock
    input  wire logic              fifo_reset_n,       // chain reset
    input  wire logic              fifo_write_n,       // write strobe
    input  wire logic              fifo_read_n,        // read strobe
    input  wire logic [8:0]        fifo_data_out,      // word written
    output logic      [8:0]        fifo_data_in,       // word read
    input  wire logic [NSLICE-1:0] first_load_strap_n, // strap / retransmit
    input  wire logic              expand_in_n,        // host pulse into slice 0
    output logic      [NSLICE-1:0] empty_flag_n,       // per-slice empty
    output logic      [NSLICE-1:0] full_flag_n,        // per-slice full
    output int                     fault_cnt           // host timing and retransmit-in-depth faults seen
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [8:0] mem [NSLICE][DEPTH];
    int         wp [NSLICE]    = '{default: 0};
    int         rp [NSLICE]    = '{default: 0};
    int         cnt [NSLICE]   = '{default: 0};
    logic       wr_ok [NSLICE] = '{default: 1'b0};
    logic       rd_ok [NSLICE] = '{default: 1'b0};
    logic       par [NSLICE]   = '{default: 1'b0};
    logic       single = 1'b1;
    logic       pw = 1'b1, pr = 1'b1, px = 1'b1, prt = 1'b1;
    int         low_cnt = 0, gap = 1000;

    initial fault_cnt = 0;
    initial fifo_data_in = 9'h000;

    // pulses alternate: first hands over writing, second reading
    task automatic grant(input int k);
        if (!par[k]) wr_ok[k] = 1'b1;
        else rd_ok[k] = 1'b1;
        par[k] = ~par[k];
    endtask

    function automatic int pick(input logic wr);
        pick = -1;
        for (int k = 0; k < NSLICE; k++) begin
            if ((single ? k == 0 : (wr ? wr_ok[k] : rd_ok[k]))
                && (wr ? cnt[k] < DEPTH : cnt[k] > 0)) pick = k;
        end
    endfunction

    always @(posedge clock) begin
        int s;
        s = -1;
        if (!fifo_reset_n) begin
            single = ~expand_in_n;
            for (int k = 0; k < NSLICE; k++) begin
                wp[k] = 0;
                rp[k] = 0;
                cnt[k] = 0;
                par[k] = 1'b0;
                wr_ok[k] = ~first_load_strap_n[k];
                rd_ok[k] = ~first_load_strap_n[k];
            end
        end else begin
            if (!single && !px && expand_in_n) begin
                if (low_cnt < C_XI_W) fault_cnt++;
                grant(0);
                gap = 0;
            end else if (gap < 1000) gap++;
            if (((pw && !fifo_write_n) || (pr && !fifo_read_n)) && gap < C_XI_REC) fault_cnt++;
            if (prt && !first_load_strap_n[0]) begin
                if (!single) fault_cnt++;
                else begin
                    rp[0] = 0;
                    cnt[0] = wp[0];
                end
            end
            if (!pw && fifo_write_n) begin
                s = pick(1'b1);
                if (s >= 0) begin
                    mem[s][wp[s]] = fifo_data_out;
                    cnt[s]++;
                    wp[s] = (wp[s] + 1) % DEPTH;
                    if (wp[s] == 0 && !single) begin
                        wr_ok[s] = 1'b0;
                        grant((s + 1) % NSLICE);
                    end
                end
            end
            if (!pr && fifo_read_n) begin
                s = pick(1'b0);
                if (s >= 0) begin
                    cnt[s]--;
                    rp[s] = (rp[s] + 1) % DEPTH;
                    if (rp[s] == 0 && !single) begin
                        rd_ok[s] = 1'b0;
                        grant((s + 1) % NSLICE);
                    end
                end
            end
        end
        low_cnt = expand_in_n ? 0 : low_cnt + 1;
        s = pick(1'b0);
        // released bus shows no stale word: it toggles every cycle
        if (!fifo_read_n && s >= 0) fifo_data_in <= mem[s][rp[s]];
        else fifo_data_in <= ~fifo_data_in;
        pw = fifo_write_n;
        pr = fifo_read_n;
        px = expand_in_n;
        prt = first_load_strap_n[0];
    end

    always_comb begin
        for (int k = 0; k < NSLICE; k++) begin
            empty_flag_n[k] = (cnt[k] != 0);
            full_flag_n[k] = (cnt[k] != DEPTH);
        end
    end
endmodule

// ===== sim/tb_fdxc_top.sv
module tb_fdxc_top
    import fdxc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NS = 3;
    localparam int DP = 2;
    logic          clock = 1'b0;
    logic          rst_n, psel, penable, pwrite, pready, pslverr, irq, err, avl;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, rd;
    logic          fifo_reset_n, fifo_write_n, fifo_read_n, reread_pulse_n, expand_in_n;
    logic [8:0]    fifo_data_out, fifo_data_in;
    logic [NS-1:0] first_load_strap_n, empty_flag_n, full_flag_n;
    logic [1:0]    st;
    int            fault_cnt, err_total, compares;

    always #2.5 clock = ~clock;

    fdxc_top #(.NSLICE(NS)) dut_u (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .fifo_reset_n(fifo_reset_n), .fifo_write_n(fifo_write_n),
        .fifo_read_n(fifo_read_n), .fifo_data_out(fifo_data_out),
        .fifo_data_in(fifo_data_in), .first_load_strap_n(first_load_strap_n),
        .reread_pulse_n(reread_pulse_n), .expand_in_n(expand_in_n),
        .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n));

    fdxc_chain_model #(.NSLICE(NS), .DEPTH(DP)) mdl_u (.clock(clock),
        .fifo_reset_n(fifo_reset_n), .fifo_write_n(fifo_write_n),
        .fifo_read_n(fifo_read_n), .fifo_data_out(fifo_data_out),
        .fifo_data_in(fifo_data_in), .first_load_strap_n(first_load_strap_n),
        .expand_in_n(expand_in_n), .empty_flag_n(empty_flag_n),
        .full_flag_n(full_flag_n), .fault_cnt(fault_cnt));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // st ends as {refused, done}, avl as data-available; all sticky bits cleared afterwards
    task automatic cmd(input logic [2:0] op, input logic [8:0] d);
        apb(1'b1, A_CMD, {20'h00000, op, d});
        st = 2'b00;
        for (int i = 0; i < 300 && st == 2'b00; i++) begin
            apb(1'b0, A_IRQ_STAT, 32'h0);
            st = rd[1:0];
        end
        avl = rd[2];
        apb(1'b1, A_IRQ_CLR, 32'h7);
    endtask

    function automatic logic [31:0] word(input int i);
        word = 32'(9'(9'h0a3 + 61 * i));
    endfunction

    initial begin
        {psel, penable, pwrite} = 3'b000;
        paddr = 8'h00;
        pwdata = 32'h0;
        rst_n = 1'b0;
        err_total = 0;
        compares = 0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        apb(1'b0, A_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, A_IRQ_EN, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h24, 32'h0);
        check({rd[30:0], err}, 32'h1);
        apb(1'b1, A_IRQ_EN, 32'h1);
        apb(1'b1, A_CTRL, 32'h1);
        cmd(OP_RESET, 9'h000);
        check(32'(st), 32'h1);
        apb(1'b0, A_STATUS, 32'h0);
        check(rd, 32'h2);
        for (int i = 0; i < NS * DP; i++) begin
            cmd(OP_WRITE, 9'(word(i)));
            check(32'(st), 32'h1);
            check(32'(avl), 32'(i == 0));
        end
        apb(1'b0, A_STATUS, 32'h0);
        check(rd, 32'h4);
        cmd(OP_WRITE, 9'h1ff);
        check(32'(st), 32'h2);
        for (int i = 0; i < NS * DP; i++) begin
            cmd(OP_READ, 9'h000);
            apb(1'b0, A_RDATA, 32'h0);
            check(rd, word(i));
        end
        cmd(OP_READ, 9'h000);
        check(32'(st), 32'h2);
        cmd(OP_REREAD, 9'h000);
        check(32'(st), 32'h2);
        cmd(OP_XI, 9'h000);
        check(32'(st), 32'h1);
        cmd(3'h0, 9'h000);
        check(32'(st), 32'h2);
        apb(1'b1, A_IRQ_EN, 32'h0);
        apb(1'b1, A_CMD, {20'h00000, 3'h7, 9'h000});
        apb(1'b0, A_IRQ_STAT, 32'h0);
        check(rd & 32'h2, 32'h2);
        check(32'(irq), 32'h0);
        apb(1'b1, A_IRQ_EN, 32'h2);
        @(posedge clock);
        check(32'(irq), 32'h1);
        apb(1'b1, A_IRQ_CLR, 32'h2);
        @(posedge clock);
        check(32'(irq), 32'h0);
        apb(1'b1, A_CTRL, 32'h0);
        cmd(OP_RESET, 9'h000);
        cmd(OP_WRITE, 9'h15a);
        cmd(OP_READ, 9'h000);
        cmd(OP_REREAD, 9'h000);
        check(32'(st), 32'h1);
        cmd(OP_READ, 9'h000);
        apb(1'b0, A_RDATA, 32'h0);
        check(rd, 32'h15a);
        cmd(OP_XI, 9'h000);
        check(32'(st), 32'h2);
        check(32'(fault_cnt), 32'h0);
        stop_test();
    end

    // the sequence needs under a thousand cycles; this is generous
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        stop_test();
    end
endmodule
